// [verilog/tof_count_pkg.sv]
// constants, field widths, reset values and state codes for the time-of-flight counting core
// assumes one reference clock domain; shared by the channel core and the coarse counter
package tof_count_pkg;

	localparam int CHANNELS = 2;
	localparam int COARSE_W = 16;
	localparam int FINE_W = 24;
	localparam int TAP_W = 6;
	localparam int REF_W = 16;
	localparam int STOPCNT_W = 3;
	localparam int CALP_W = 8;
	localparam int FINE_SLOTS = 6;
	localparam int REF_SLOTS = 5;

	// ring taps per wrap; one coarse step is this many fine steps
	localparam int RING_TAPS = 63;
	localparam logic [STOPCNT_W-1:0] MAX_STOPS = 3'h5;
	localparam logic [STOPCNT_W-1:0] ONE_STOP = 3'h1;
	localparam logic [CALP_W-1:0] SINGLE_CAL_PERIODS = 8'h01;

	// reference clock period, for converting counts to time
	localparam int CLK_PERIOD_NS = 40;

	localparam logic [FINE_W-1:0] RST_FINE = 24'h00_0000;
	localparam logic [REF_W-1:0] RST_REF = 16'h0000;
	localparam logic [COARSE_W-1:0] RST_COARSE = 16'h0000;
	localparam logic [STOPCNT_W-1:0] RST_STOPIDX = 3'h0;
	localparam logic [CALP_W-1:0] RST_CALCNT = 8'h00;

	typedef enum logic [4:0] {
		ST_IDLE       = 5'b0_0001,
		ST_WAIT_START = 5'b0_0010,
		ST_MEASURE    = 5'b0_0100,
		ST_CAL_SINGLE = 5'b0_1000,
		ST_CAL_MULTI  = 5'b1_0000
	} chan_state_e;

endpackage

// [verilog/ring_coarse_counter.sv]
// coarse counter: counts ring oscillator wraps and forms the fine interval value
// assumes wrap pulses and the tap position are synchronous to the reference clock
`timescale 1ns/1ps
`default_nettype none

module ring_coarse_counter
	import tof_count_pkg::*;
#(
	parameter int CW = COARSE_W,
	parameter int FW = FINE_W,
	parameter int TW = TAP_W
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic run,
	input wire logic clear,
	input wire logic wrap,
	input wire logic [TW-1:0] tap,
	output logic [CW-1:0] coarse,
	output logic [FW-1:0] fine
);

	logic [CW-1:0] coarse_q;
	logic [CW-1:0] coarse_d;

	always_comb begin
		coarse_d = coarse_q;
		if (clear) begin
			coarse_d = RST_COARSE;
		end else if (run && wrap && (coarse_q != {CW{1'b1}})) begin
			coarse_d = coarse_q + CW'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			coarse_q <= RST_COARSE;
		end else if (ce) begin
			coarse_q <= coarse_d;
		end
	end

	assign coarse = coarse_q;
	// fine value is wraps times taps-per-wrap plus the current tap
	assign fine = FW'(FW'(coarse_q) * FW'(RING_TAPS)) + FW'(tap);

endmodule

`default_nettype wire

// [verilog/tof_counter_core.sv]
// two-channel time-of-flight counting core: coarse and reference-cycle counters,
// overflow limits and flags, stop-ignore window and two-point calibration.
// assumes START, STOP, ring wrap and tap inputs are synchronous to CLK; CLK is the reference clock.
// Summary of operation
// - both channels share clock, separate logic
// - coarse counter counts ring wraps, fine results
// - reference cycles counted in long-range mode
// - coarse flag when fine/63 reaches limit
// - clock flag when reference count reaches limit
// - overflow terminates measurement immediately
// - reference count starts edge after start
// - long range: stops inside ignore window are dropped
// - enable low holds logic in reset
// - calibrate one period, then programmed periods
// - store both calibration counts
// - calibrate after completion, not after abort
// - up to five stops, end on last
// - wait for start forever, no flag
`timescale 1ns/1ps
`default_nettype none

module tof_counter_core
	import tof_count_pkg::*;
#(
	parameter int NCH = CHANNELS,
	parameter int CW = COARSE_W,
	parameter int FW = FINE_W,
	parameter int TW = TAP_W,
	parameter int RW = REF_W
) (
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic CE,
	input wire logic ENABLE,
	input wire logic [NCH-1:0] MEAS_GO,
	input wire logic [NCH-1:0] LONG_RANGE_MODE,
	input wire logic [NCH-1:0][STOPCNT_W-1:0] STOP_COUNT,
	input wire logic [NCH-1:0][CALP_W-1:0] CALIBRATION_PERIOD_COUNT,
	input wire logic [NCH-1:0][7:0] COARSE_OVERFLOW_LIMIT_H,
	input wire logic [NCH-1:0][7:0] COARSE_OVERFLOW_LIMIT_L,
	input wire logic [NCH-1:0][7:0] REFCYCLE_OVERFLOW_LIMIT_H,
	input wire logic [NCH-1:0][7:0] REFCYCLE_OVERFLOW_LIMIT_L,
	input wire logic [NCH-1:0][7:0] STOP_IGNORE_WINDOW_H,
	input wire logic [NCH-1:0][7:0] STOP_IGNORE_WINDOW_L,
	input wire logic [NCH-1:0] FLAG_CLEAR,
	input wire logic [NCH-1:0] START,
	input wire logic [NCH-1:0] STOP,
	input wire logic [NCH-1:0] RING_WRAP,
	input wire logic [NCH-1:0][TW-1:0] RING_TAP,
	output logic [NCH-1:0][FINE_SLOTS-1:0][FW-1:0] FINE_INTERVAL_RESULT,
	output logic [NCH-1:0][REF_SLOTS-1:0][RW-1:0] REFCYCLE_INTERVAL_RESULT,
	output logic [NCH-1:0][FW-1:0] SINGLE_PERIOD_CAL_RESULT,
	output logic [NCH-1:0][FW-1:0] MULTI_PERIOD_CAL_RESULT,
	output logic [NCH-1:0] COARSE_OVERFLOW_FLAG,
	output logic [NCH-1:0] REFCYCLE_OVERFLOW_FLAG,
	output logic [NCH-1:0] MEAS_BUSY,
	output logic [NCH-1:0] INTERRUPT_REQUEST_PIN_N
);

	logic rst_n;
	assign rst_n = RESETN & ENABLE;

	for (genvar c = 0; c < NCH; c++) begin : g_chan
		chan_state_e st_q;
		chan_state_e st_d;
		logic [STOPCNT_W-1:0] stop_idx_q;
		logic [STOPCNT_W-1:0] stop_idx_d;
		logic [RW-1:0] ref_q;
		logic [RW-1:0] ref_d;
		logic [CALP_W-1:0] cal_cnt_q;
		logic [CALP_W-1:0] cal_cnt_d;
		logic [FW-1:0] fine_q [FINE_SLOTS];
		logic [FW-1:0] fine_d [FINE_SLOTS];
		logic [RW-1:0] ref_res_q [REF_SLOTS];
		logic [RW-1:0] ref_res_d [REF_SLOTS];
		logic [FW-1:0] cal1_q;
		logic [FW-1:0] cal1_d;
		logic [FW-1:0] cal2_q;
		logic [FW-1:0] cal2_d;
		logic cov_q;
		logic cov_d;
		logic rov_q;
		logic rov_d;
		logic irq_n_q;
		logic irq_n_d;
		logic busy_q;
		logic busy_d;
		logic ring_run;
		logic ring_clear;
		logic [CW-1:0] coarse;
		logic [FW-1:0] fine_now;
		logic [CW-1:0] coarse_lim;
		logic [RW-1:0] ref_lim;
		logic [RW-1:0] window;
		logic [STOPCNT_W-1:0] stops_wanted;
		logic [CALP_W-1:0] cal_periods;
		logic long_mode;
		logic stop_ok;
		logic last_stop;
		logic coarse_hit;
		logic ref_hit;

		// limit is high byte times 256 plus low byte
		assign coarse_lim = CW'({COARSE_OVERFLOW_LIMIT_H[c], COARSE_OVERFLOW_LIMIT_L[c]});
		assign ref_lim = RW'({REFCYCLE_OVERFLOW_LIMIT_H[c], REFCYCLE_OVERFLOW_LIMIT_L[c]});
		assign window = RW'({STOP_IGNORE_WINDOW_H[c], STOP_IGNORE_WINDOW_L[c]});
		assign long_mode = LONG_RANGE_MODE[c];

		// zero reads as one stop, above five clamps to five
		assign stops_wanted = (STOP_COUNT[c] == RST_STOPIDX) ? ONE_STOP :
			((STOP_COUNT[c] > MAX_STOPS) ? MAX_STOPS : STOP_COUNT[c]);
		assign cal_periods = (CALIBRATION_PERIOD_COUNT[c] == RST_CALCNT) ? SINGLE_CAL_PERIODS :
			CALIBRATION_PERIOD_COUNT[c];

		// coarse count equals fine result over 63
		assign coarse_hit = (coarse >= coarse_lim);
		// clock count reaches limit in long-range mode
		assign ref_hit = long_mode && (ref_q >= ref_lim);
		// long range: stop ignored while count below window
		assign stop_ok = STOP[c] && (!long_mode || (ref_q >= window));
		assign last_stop = (stop_idx_q + STOPCNT_W'(1)) >= stops_wanted;

		ring_coarse_counter #(
			.CW(CW),
			.FW(FW),
			.TW(TW)
		) u_coarse (
			.clk(CLK),
			.rst_n(rst_n),
			.ce(CE),
			.run(ring_run),
			.clear(ring_clear),
			.wrap(RING_WRAP[c]),
			.tap(RING_TAP[c]),
			.coarse(coarse),
			.fine(fine_now)
		);

		always_comb begin
			st_d = st_q;
			stop_idx_d = stop_idx_q;
			ref_d = ref_q;
			cal_cnt_d = cal_cnt_q;
			cal1_d = cal1_q;
			cal2_d = cal2_q;
			cov_d = cov_q;
			rov_d = rov_q;
			irq_n_d = irq_n_q;
			busy_d = busy_q;
			ring_run = 1'b0;
			ring_clear = 1'b0;
			for (int i = 0; i < FINE_SLOTS; i++) begin
				fine_d[i] = fine_q[i];
			end
			for (int i = 0; i < REF_SLOTS; i++) begin
				ref_res_d[i] = ref_res_q[i];
			end
			// host clear, overridden below by a new overflow
			if (FLAG_CLEAR[c]) begin
				cov_d = 1'b0;
				rov_d = 1'b0;
				irq_n_d = 1'b1;
			end
			case (st_q)
				ST_IDLE: begin
					ring_clear = 1'b1;
					busy_d = 1'b0;
					if (MEAS_GO[c]) begin
						st_d = ST_WAIT_START;
						busy_d = 1'b1;
						irq_n_d = 1'b1;
					end
				end
				ST_WAIT_START: begin
					ring_clear = 1'b1;
					stop_idx_d = RST_STOPIDX;
					ref_d = RST_REF;
					if (START[c]) begin
						st_d = ST_MEASURE;
						// long range: first fine slot holds the start fraction
						if (long_mode) begin
							fine_d[0] = fine_now;
						end
					end
				end
				ST_MEASURE: begin
					// short range runs the ring across the whole interval; long range keeps it off
					ring_run = !long_mode;
					// count from the edge after start
					if (long_mode && (ref_q != {RW{1'b1}})) begin
						ref_d = ref_q + RW'(1);
					end
					if (coarse_hit || ref_hit) begin
						// build on the cleared value so a same-cycle clear of the other flag still lands
						cov_d = cov_d | coarse_hit;
						rov_d = rov_d | ref_hit;
						irq_n_d = 1'b0;
						busy_d = 1'b0;
						st_d = ST_IDLE;
					end else if (stop_ok) begin
						// capture each stop, finish on last
						if (long_mode) begin
							fine_d[stop_idx_q + STOPCNT_W'(1)] = fine_now;
							ref_res_d[stop_idx_q] = ref_q;
						end else begin
							fine_d[stop_idx_q] = fine_now;
						end
						stop_idx_d = stop_idx_q + STOPCNT_W'(1);
						if (last_stop) begin
							st_d = ST_CAL_SINGLE;
							ring_clear = 1'b1;
							cal_cnt_d = RST_CALCNT;
						end
					end
				end
				ST_CAL_SINGLE: begin
					ring_run = 1'b1;
					if (cal_cnt_q + CALP_W'(1) >= SINGLE_CAL_PERIODS) begin
						cal1_d = fine_now;
						ring_clear = 1'b1;
						cal_cnt_d = RST_CALCNT;
						st_d = ST_CAL_MULTI;
					end else begin
						cal_cnt_d = cal_cnt_q + CALP_W'(1);
					end
				end
				ST_CAL_MULTI: begin
					ring_run = 1'b1;
					if (cal_cnt_q + CALP_W'(1) >= cal_periods) begin
						cal2_d = fine_now;
						irq_n_d = 1'b0;
						busy_d = 1'b0;
						st_d = ST_IDLE;
					end else begin
						cal_cnt_d = cal_cnt_q + CALP_W'(1);
					end
				end
				default: begin
					st_d = ST_IDLE;
				end
			endcase
		end

		always_ff @(posedge CLK) begin
			if (!rst_n) begin
				st_q <= ST_IDLE;
				stop_idx_q <= RST_STOPIDX;
				ref_q <= RST_REF;
				cal_cnt_q <= RST_CALCNT;
				cal1_q <= RST_FINE;
				cal2_q <= RST_FINE;
				cov_q <= 1'b0;
				rov_q <= 1'b0;
				irq_n_q <= 1'b1;
				busy_q <= 1'b0;
				for (int i = 0; i < FINE_SLOTS; i++) begin
					fine_q[i] <= RST_FINE;
				end
				for (int i = 0; i < REF_SLOTS; i++) begin
					ref_res_q[i] <= RST_REF;
				end
			end else if (CE) begin
				st_q <= st_d;
				stop_idx_q <= stop_idx_d;
				ref_q <= ref_d;
				cal_cnt_q <= cal_cnt_d;
				cal1_q <= cal1_d;
				cal2_q <= cal2_d;
				cov_q <= cov_d;
				rov_q <= rov_d;
				irq_n_q <= irq_n_d;
				busy_q <= busy_d;
				for (int i = 0; i < FINE_SLOTS; i++) begin
					fine_q[i] <= fine_d[i];
				end
				for (int i = 0; i < REF_SLOTS; i++) begin
					ref_res_q[i] <= ref_res_d[i];
				end
			end
		end

		for (genvar i = 0; i < FINE_SLOTS; i++) begin : g_fine_out
			assign FINE_INTERVAL_RESULT[c][i] = fine_q[i];
		end
		for (genvar i = 0; i < REF_SLOTS; i++) begin : g_ref_out
			assign REFCYCLE_INTERVAL_RESULT[c][i] = ref_res_q[i];
		end
		assign SINGLE_PERIOD_CAL_RESULT[c] = cal1_q;
		assign MULTI_PERIOD_CAL_RESULT[c] = cal2_q;
		assign COARSE_OVERFLOW_FLAG[c] = cov_q;
		assign REFCYCLE_OVERFLOW_FLAG[c] = rov_q;
		assign MEAS_BUSY[c] = busy_q;
		assign INTERRUPT_REQUEST_PIN_N[c] = irq_n_q;
	end

endmodule

`default_nettype wire

// [dv/tof_core_properties.sv]
// checker: reset, overflow, completion and flag relations on channel 0
// assumes it is bound to tof_counter_core; CE drops only inside a running measurement
`timescale 1ns/1ps
`default_nettype none
module tof_core_properties
	import tof_count_pkg::*;
#(
	parameter int NCH = CHANNELS,
	parameter int FW = FINE_W
) (
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic ENABLE,
	input wire logic [NCH-1:0] MEAS_GO,
	input wire logic [NCH-1:0] START,
	input wire logic [NCH-1:0] FLAG_CLEAR,
	input wire logic [NCH-1:0][FINE_SLOTS-1:0][FW-1:0] FINE_INTERVAL_RESULT,
	input wire logic [NCH-1:0][FW-1:0] SINGLE_PERIOD_CAL_RESULT,
	input wire logic [NCH-1:0][FW-1:0] MULTI_PERIOD_CAL_RESULT,
	input wire logic [NCH-1:0] COARSE_OVERFLOW_FLAG,
	input wire logic [NCH-1:0] REFCYCLE_OVERFLOW_FLAG,
	input wire logic [NCH-1:0] MEAS_BUSY,
	input wire logic [NCH-1:0] INTERRUPT_REQUEST_PIN_N
);
	wire logic busy = MEAS_BUSY[0];
	wire logic irq_n = INTERRUPT_REQUEST_PIN_N[0];
	wire logic cflag = COARSE_OVERFLOW_FLAG[0];
	wire logic rflag = REFCYCLE_OVERFLOW_FLAG[0];
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESETN || !ENABLE);
	a_reset_clears:
	assert property (disable iff (1'b0) !RESETN || !ENABLE |=> !busy && irq_n && !cflag && !rflag
		&& FINE_INTERVAL_RESULT[0] == '0) else $error("state not cleared by reset");
	a_wait_start:
	assert property (MEAS_GO[0] && !busy ##1 !START[0] [*8] |-> busy && irq_n) else $error("gave up waiting");
	a_flags_sticky:
	assert property ((cflag || rflag) && !FLAG_CLEAR[0] && !MEAS_GO[0] |=> (cflag || rflag) && !irq_n)
		else $error("flag dropped");
	a_clear_releases:
	assert property (FLAG_CLEAR[0] && !busy |=> !cflag && !rflag && irq_n) else $error("clear ignored");
	a_refcycle_ends:
	assert property ($rose(rflag) |-> !busy && !irq_n) else $error("run kept going");
	a_coarse_ends:
	assert property ($rose(cflag) |-> !busy && !irq_n) else $error("run kept going");
	a_cal_skipped:
	assert property ($rose(cflag || rflag) |-> $stable(SINGLE_PERIOD_CAL_RESULT[0])
		&& $stable(MULTI_PERIOD_CAL_RESULT[0])) else $error("calibrated after abort");
	a_done_irq:
	assert property ($fell(busy) && $past(RESETN && ENABLE) |-> !irq_n) else $error("no completion irq");
	c_ref_ovf: cover property ($rose(rflag));
	c_coarse_ovf: cover property ($rose(cflag));
	c_done: cover property ($fell(busy) && !cflag && !rflag);
endmodule
`default_nettype wire

// [dv/pulse_front_end.sv]
// front end model: start pulse, stop train and ring wrap/tap for one channel
// assumes fire is a one-cycle pulse given while the channel waits for a start
`timescale 1ns/1ps
`default_nettype none
module pulse_front_end (
	input wire logic clk,
	input wire logic fire,
	input wire logic [2:0] n_stops,
	input wire logic [7:0] gap,
	input wire logic wrap_on,
	input wire logic [5:0] base,
	output logic start,
	output logic stop,
	output logic wrap,
	output logic [5:0] tap
);
	initial begin
		start = 1'b0;
		stop = 1'b0;
		wrap = 1'b0;
		tap = 6'h3f;
	end
	always @(posedge clk) begin
		wrap <= wrap_on & ~wrap;
	end
	// idle tap is 0x3f so a sample taken off an event stands out
	always @(posedge clk) begin
		if (fire) begin
			start <= 1'b1;
			tap <= base;
			@(posedge clk);
			start <= 1'b0;
			tap <= 6'h3f;
			for (int k = 0; k < n_stops; k++) begin
				repeat (gap - 1) @(posedge clk);
				stop <= 1'b1;
				tap <= base + 6'(k + 1);
				@(posedge clk);
				stop <= 1'b0;
				tap <= 6'h3f;
			end
		end
	end
endmodule
`default_nettype wire

// [dv/testbench.sv]
// self-checking bench for the two-channel counting core
// assumes pulse_front_end drives each channel's start, stop and ring inputs
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic CLK = 1'b0;
	logic RESETN = 1'b0;
	logic CE = 1'b1;
	logic ENABLE = 1'b0;
	logic [1:0] MEAS_GO = '0, LONG_RANGE_MODE = '0, FLAG_CLEAR = '0, START, STOP, RING_WRAP;
	logic [1:0] MEAS_BUSY, INTERRUPT_REQUEST_PIN_N, COARSE_OVERFLOW_FLAG, REFCYCLE_OVERFLOW_FLAG;
	logic [1:0][2:0] STOP_COUNT = '0;
	logic [1:0][5:0] RING_TAP;
	logic [1:0][7:0] CALIBRATION_PERIOD_COUNT = '0, COARSE_OVERFLOW_LIMIT_H = '1, COARSE_OVERFLOW_LIMIT_L = '1;
	logic [1:0][7:0] REFCYCLE_OVERFLOW_LIMIT_H = '1, REFCYCLE_OVERFLOW_LIMIT_L = '1;
	logic [1:0][7:0] STOP_IGNORE_WINDOW_H = '0, STOP_IGNORE_WINDOW_L = '0;
	logic [1:0][5:0][23:0] FINE_INTERVAL_RESULT;
	logic [1:0][4:0][15:0] REFCYCLE_INTERVAL_RESULT;
	logic [1:0][23:0] SINGLE_PERIOD_CAL_RESULT, MULTI_PERIOD_CAL_RESULT;
	logic [1:0] fire = '0, wrap_on = '0;
	logic [1:0][2:0] n_stops = '0;
	logic [1:0][7:0] gap = '0;
	int error_cnt = 0, n_compared = 0;
	tof_counter_core DUT (.*);
	for (genvar i = 0; i < 2; i++) begin : g_fe
		pulse_front_end fe (.clk(CLK), .fire(fire[i]), .n_stops(n_stops[i]), .gap(gap[i]), .wrap_on(wrap_on[i]),
			.base(6'(16 + 16 * i)), .start(START[i]), .stop(STOP[i]), .wrap(RING_WRAP[i]), .tap(RING_TAP[i]));
	end
	// clock runs for the whole time enable is high
	initial begin
		forever #20 CLK = ~CLK;
	end
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tally_and_finish;
		$display("compared %0d mismatched %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// idle edges first so a stop train still in flight cannot swallow the next fire
	task automatic cfg(input int ch, lr, ns, cp, input logic [15:0] cov, rov, win);
		repeat (4) @(posedge CLK);
		LONG_RANGE_MODE[ch] <= lr[0];
		STOP_COUNT[ch] <= ns[2:0];
		CALIBRATION_PERIOD_COUNT[ch] <= cp[7:0];
		{COARSE_OVERFLOW_LIMIT_H[ch], COARSE_OVERFLOW_LIMIT_L[ch]} <= cov;
		{REFCYCLE_OVERFLOW_LIMIT_H[ch], REFCYCLE_OVERFLOW_LIMIT_L[ch]} <= rov;
		{STOP_IGNORE_WINDOW_H[ch], STOP_IGNORE_WINDOW_L[ch]} <= win;
	endtask
	task automatic launch(input int ch, ns, g, w);
		@(posedge CLK);
		MEAS_GO[ch] <= 1'b1;
		@(posedge CLK);
		MEAS_GO[ch] <= 1'b0;
		fire[ch] <= 1'b1;
		n_stops[ch] <= ns[2:0];
		gap[ch] <= g[7:0];
		wrap_on[ch] <= w[0];
		@(posedge CLK);
		fire[ch] <= 1'b0;
	endtask
	// since = edges from the last start or stop taken to the edge that drops busy
	task automatic finish_run(input int ch, output int since);
		since = 0;
		for (int n = 0; n < 2000; n++) begin
			@(posedge CLK);
			since = (STOP[ch] || START[ch]) ? 0 : since + 1;
			#1;
			if (!MEAS_BUSY[ch])
				return;
		end
		check("run end", 0, 1);
	endtask
	task automatic clear(input int ch);
		@(posedge CLK);
		FLAG_CLEAR[ch] <= 1'b1;
		@(posedge CLK);
		FLAG_CLEAR[ch] <= 1'b0;
		#1;
	endtask
	task automatic t_short_stops;
		int since;
		// seven stops asked for: must clamp to five
		cfg(0, 0, 7, 2, 16'hffff, 16'hffff, 16'h0000);
		cfg(1, 0, 1, 1, 16'hffff, 16'hffff, 16'h0000);
		launch(0, 5, 3, 0);
		launch(1, 1, 2, 0);
		finish_run(0, since);
		check("cal span", 3, since);
		for (int k = 0; k < 5; k++)
			check("fine slot", 24'h11 + k, FINE_INTERVAL_RESULT[0][k]);
		check("cal one", 24'h3f, SINGLE_PERIOD_CAL_RESULT[0]);
		check("cal many", 24'h3f, MULTI_PERIOD_CAL_RESULT[0]);
		check("done irq", 0, INTERRUPT_REQUEST_PIN_N[0]);
		check("ch1 slot", 24'h21, FINE_INTERVAL_RESULT[1][0]);
	endtask
	task automatic t_long(input int win, ns, g, cnt, input logic [23:0] tp);
		int since;
		// overflow limit kept above the ignore window
		// zero stops and zero periods must act as one of each
		cfg(0, 1, 0, 0, 16'hffff, 16'h0100, win[15:0]);
		launch(0, ns, g, 0);
		finish_run(0, since);
		check("ref count", cnt, REFCYCLE_INTERVAL_RESULT[0][0]);
		check("start tap", 24'h10, FINE_INTERVAL_RESULT[0][0]);
		check("stop tap", tp, FINE_INTERVAL_RESULT[0][1]);
	endtask
	task automatic t_ref_ovf;
		int since;
		logic [23:0] cal;
		cal = SINGLE_PERIOD_CAL_RESULT[0];
		cfg(0, 1, 1, 1, 16'hffff, 16'h0014, 16'h0000);
		launch(0, 0, 1, 0);
		// freeze five edges mid-count: the overflow edge must slip by exactly that much
		fork
			finish_run(0, since);
			begin
				repeat (6) @(posedge CLK);
				CE <= 1'b0;
				repeat (5) @(posedge CLK);
				CE <= 1'b1;
			end
		join
		check("ovf span", 26, since);
		check("cal kept", cal, SINGLE_PERIOD_CAL_RESULT[0]);
		repeat (10) @(posedge CLK);
		check("flag held", 1, REFCYCLE_OVERFLOW_FLAG[0]);
		clear(0);
		check("flag gone", 0, REFCYCLE_OVERFLOW_FLAG[0]);
		check("irq gone", 1, INTERRUPT_REQUEST_PIN_N[0]);
	endtask
	task automatic t_coarse_ovf;
		int since;
		cfg(0, 0, 1, 1, 16'h0003, 16'hffff, 16'h0000);
		launch(0, 0, 1, 1);
		finish_run(0, since);
		check("coarse flag", 1, COARSE_OVERFLOW_FLAG[0]);
		check("ref flag", 0, REFCYCLE_OVERFLOW_FLAG[0]);
		clear(0);
	endtask
	task automatic t_no_start;
		cfg(0, 0, 1, 1, 16'hffff, 16'hffff, 16'h0000);
		@(posedge CLK);
		MEAS_GO[0] <= 1'b1;
		wrap_on[0] <= 1'b0;
		@(posedge CLK);
		MEAS_GO[0] <= 1'b0;
		repeat (60) @(posedge CLK);
		#1 check("waiting", 1, MEAS_BUSY[0]);
		check("no irq", 1, INTERRUPT_REQUEST_PIN_N[0]);
		@(posedge CLK);
		ENABLE <= 1'b0;
		repeat (2) @(posedge CLK);
		ENABLE <= 1'b1;
		#1 check("busy reset", 0, MEAS_BUSY[0]);
		check("slot reset", 0, FINE_INTERVAL_RESULT[0][0]);
	endtask
	initial begin
		// one clean enable rise after power-up
		repeat (3) @(posedge CLK);
		RESETN <= 1'b1;
		ENABLE <= 1'b1;
		t_short_stops();
		t_long(0, 1, 5, 4, 24'h11);
		t_long(4, 2, 4, 7, 24'h12);
		t_long(3, 2, 4, 3, 24'h11);
		t_ref_ovf();
		t_coarse_ovf();
		t_no_start();
		tally_and_finish();
	end
	initial begin
		repeat (20000) @(posedge CLK);
		error_cnt++;
		tally_and_finish();
	end
endmodule
bind tof_counter_core tof_core_properties #(.NCH(NCH), .FW(FW)) u_props (.*);
`default_nettype wire
